// file: tmr1_channel.sv
// Channel 1 output-mode logic with APB register access
`timescale 1ns/1ps

// Overview of operation
// R1 - Mode is four bits: top bit at config bit 8, rest at bits 2..0.
// R2 - Modes 0..3: hold, low on match, high on match, toggle on match.
// R3 - Mode 4 forces reference low, mode 5 forces it high.
// R4 - PWM1: up active below compare; down inactive above compare.
// R5 - PWM2: up inactive below compare; down active above compare.
// R6 - Asym PWM1: like PWM1 but down-count compares against asymmetric value.
// R7 - Asym PWM2: like PWM2 but down-count compares against asymmetric value.
// R8 - Software sets centre-aligned counting before using asymmetric modes.
// R9 - Immediate active: trigger forces matched level until overflow or underflow.
// R10 - Preload off writes compare directly; preload on writes a buffer.
// R11 - With preload on, update event copies buffer into active compare.
module tmr1_channel (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [tmr1_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [tmr1_pkg::CNT_W-1:0]  counter_value,
  input  wire logic                        count_down,
  input  wire logic                        update_event,
  input  wire logic                        trigger_event,
  input  wire logic                        ovf_udf_event,
  output logic                             output_reference_signal
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic addr_is(input logic [tmr1_pkg::ADDR_W-1:0] a,
                                   input logic [tmr1_pkg::ADDR_W-1:0] ofs);
    addr_is = (a == ofs);
  endfunction

  function automatic logic [31:0] cfg_word(input tmr1_pkg::tmr1_state_s s);
    logic [31:0] w;
    w = tmr1_pkg::CFG_RST;
    w[tmr1_pkg::MODE_HI_BIT] = s.mode[3];
    w[2:0] = s.mode[2:0];
    w[tmr1_pkg::IMAE_BIT] = s.imae;
    w[tmr1_pkg::PRE_BIT] = s.pre;
    cfg_word = w;
  endfunction

  function automatic logic is_pwm12(input logic [3:0] m);
    is_pwm12 = (m == tmr1_pkg::OM_PWM1) || (m == tmr1_pkg::OM_PWM2);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  tmr1_pkg::tmr1_state_s state_ff;
  tmr1_pkg::tmr1_state_s nxt_state;

  logic        wr_acc;
  logic        rd_setup;
  logic        match_now;
  logic        match_edge;
  logic        ref_nxt;
  logic        force_eff;
  logic [31:0] stat_word;

  // Zero-wait slave; read data is latched in the setup cycle
  assign pready   = 1'b1;
  assign prdata   = state_ff.rdata;
  assign pslverr  = state_ff.slverr;
  assign output_reference_signal = state_ff.oref;

  assign wr_acc    = psel & penable & pwrite;
  assign rd_setup  = psel & ~penable;
  assign match_now = (counter_value == state_ff.cmp_act);
  // Edge only: a counter parked on the compare value must not toggle every clock
  assign match_edge = match_now & ~state_ff.match_d;
  // Force only counts while the option is live, so leaving PWM1/PWM2 or clearing the enable drops it at once
  assign force_eff = state_ff.force_on & state_ff.imae & is_pwm12(state_ff.mode); // R9

  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[tmr1_pkg::STAT_REF] = state_ff.oref;
    stat_word[tmr1_pkg::STAT_FORCE] = state_ff.force_on;
    stat_word[tmr1_pkg::STAT_CMP_LO +: tmr1_pkg::CNT_W] = state_ff.cmp_act;
  end

  // ----------------------------------------------------------------
  // Output level
  // ----------------------------------------------------------------
  tmr1_oref_calc u_calc (
    .mode       (state_ff.mode),
    .cnt        (counter_value),
    .cmp        (state_ff.cmp_act),
    .acmp       (state_ff.acmp_act),
    .down       (count_down),
    .ref_q      (state_ff.oref),
    .match_edge (match_edge),
    .force_on   (force_eff),
    .ref_nxt    (ref_nxt)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_state.match_d = match_now;
    nxt_state.oref = ref_nxt;

    // Buffer to active copy before any write of this cycle
    if (update_event && state_ff.pre) begin
      nxt_state.cmp_act = state_ff.cmp_buf; // R11
      nxt_state.acmp_act = state_ff.acmp_buf; // R11
    end

    if (wr_acc) begin
      if (addr_is(paddr, tmr1_pkg::CFG_OFS)) begin
        nxt_state.mode = {pwdata[tmr1_pkg::MODE_HI_BIT], pwdata[2:0]}; // R1
        nxt_state.imae = pwdata[tmr1_pkg::IMAE_BIT];
        nxt_state.pre = pwdata[tmr1_pkg::PRE_BIT];
      end
      if (addr_is(paddr, tmr1_pkg::CMP_OFS)) begin
        nxt_state.cmp_buf = pwdata[tmr1_pkg::CNT_W-1:0]; // R10
        if (!state_ff.pre) begin
          nxt_state.cmp_act = pwdata[tmr1_pkg::CNT_W-1:0]; // R10
        end
      end
      if (addr_is(paddr, tmr1_pkg::ACMP_OFS)) begin
        nxt_state.acmp_buf = pwdata[tmr1_pkg::CNT_W-1:0]; // R10
        if (!state_ff.pre) begin
          nxt_state.acmp_act = pwdata[tmr1_pkg::CNT_W-1:0]; // R10
        end
      end
    end

    // Trigger beats a same-cycle overflow so the pulse is not lost
    if (!state_ff.imae || !is_pwm12(state_ff.mode)) begin
      nxt_state.force_on = 1'b0; // R9
    end else if (trigger_event) begin
      nxt_state.force_on = 1'b1; // R9
    end else if (ovf_udf_event) begin
      nxt_state.force_on = 1'b0; // R9
    end

    if (rd_setup) begin
      nxt_state.slverr = 1'b0;
      nxt_state.rdata = 32'h0000_0000;
      if (addr_is(paddr, tmr1_pkg::CFG_OFS)) begin
        nxt_state.rdata = cfg_word(state_ff);
      end else if (addr_is(paddr, tmr1_pkg::CMP_OFS)) begin
        nxt_state.rdata[tmr1_pkg::CNT_W-1:0] = state_ff.cmp_buf;
      end else if (addr_is(paddr, tmr1_pkg::ACMP_OFS)) begin
        nxt_state.rdata[tmr1_pkg::CNT_W-1:0] = state_ff.acmp_buf;
      end else if (addr_is(paddr, tmr1_pkg::STAT_OFS)) begin
        nxt_state.rdata = stat_word;
      end else begin
        nxt_state.slverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff.mode     <= 4'h0;
      state_ff.imae     <= 1'b0;
      state_ff.pre      <= 1'b0;
      state_ff.cmp_act  <= tmr1_pkg::CMP_RST;
      state_ff.cmp_buf  <= tmr1_pkg::CMP_RST;
      state_ff.acmp_act <= tmr1_pkg::CMP_RST;
      state_ff.acmp_buf <= tmr1_pkg::CMP_RST;
      state_ff.oref     <= 1'b0;
      state_ff.force_on <= 1'b0;
      state_ff.match_d  <= 1'b0;
      state_ff.rdata    <= 32'h0000_0000;
      state_ff.slverr   <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule // tmr1_channel

// file: tmr1_channel_monitor.sv
// Checker for the channel 1 output-mode block
`timescale 1ns/1ps

module tmr1_channel_monitor (
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [tmr1_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                 pwdata,
  input wire logic [tmr1_pkg::CNT_W-1:0]  counter_value,
  input wire logic                        count_down,
  input wire logic                        update_event,
  input wire logic                        trigger_event,
  input wire logic                        output_reference_signal
);
  // ------------------------------------------------------------
  // Shadow of mode and compares, kept from bus writes and update events
  // ------------------------------------------------------------
  logic [3:0]  mode_ff;
  logic        imae_ff;
  logic        pre_ff;
  logic [15:0] cmp_ff, cbuf_ff, acmp_ff, abuf_ff;
  wire logic   wr  = psel & penable & pwrite;
  wire logic   lt  = counter_value < cmp_ff;
  wire logic   gtc = counter_value > cmp_ff;
  wire logic   gta = counter_value > acmp_ff;
  wire logic   oref = output_reference_signal;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {mode_ff, imae_ff, pre_ff} <= 6'h00;
      {cmp_ff, cbuf_ff, acmp_ff, abuf_ff} <= 64'h0;
    end else begin
      if (wr && paddr == tmr1_pkg::CFG_OFS) begin
        mode_ff <= {pwdata[8], pwdata[2:0]};
        imae_ff <= pwdata[5];
        pre_ff  <= pwdata[4];
      end
      if (update_event && pre_ff) begin
        cmp_ff  <= cbuf_ff;
        acmp_ff <= abuf_ff;
      end
      if (wr && paddr == tmr1_pkg::CMP_OFS) begin
        cbuf_ff <= pwdata[15:0];
        if (!pre_ff) cmp_ff <= pwdata[15:0];
      end
      if (wr && paddr == tmr1_pkg::ACMP_OFS) begin
        abuf_ff <= pwdata[15:0];
        if (!pre_ff) acmp_ff <= pwdata[15:0];
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_hold; mode_ff == 4'h0 |=> $stable(oref); endproperty
  a_hold: assert property (p_hold) else $error("reference moved in hold mode");
  property p_set_clr;
    mode_ff inside {4'h1, 4'h2} && $rose(counter_value == cmp_ff) |=> oref == $past(mode_ff[1]);
  endproperty
  a_set_clr: assert property (p_set_clr) else $error("match level wrong");
  property p_toggle; mode_ff == 4'h3 && $rose(counter_value == cmp_ff) |=> oref != $past(oref);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle on match");
  property p_forced; mode_ff inside {4'h4, 4'h5} |=> oref == $past(mode_ff[0]); endproperty
  a_forced: assert property (p_forced) else $error("forced level wrong");
  property p_pwm_up;
    mode_ff[2:1] == 2'b11 && !imae_ff && !count_down |=> oref == $past(lt ^ mode_ff[0]);
  endproperty
  a_pwm_up: assert property (p_pwm_up) else $error("up-count pwm level wrong");
  property p_pwm_dn;
    mode_ff inside {4'h6, 4'h7} && !imae_ff && count_down |=> oref == $past(!gtc ^ mode_ff[0]);
  endproperty
  a_pwm_dn: assert property (p_pwm_dn) else $error("down-count pwm level wrong");
  property p_apwm_dn;
    mode_ff inside {4'he, 4'hf} && count_down |=> oref == $past(!gta ^ mode_ff[0]);
  endproperty
  a_apwm_dn: assert property (p_apwm_dn) else $error("asym down level wrong");
  property p_imae;
    mode_ff[3:1] == 3'b011 && imae_ff && trigger_event |-> ##2 oref == $past(mode_ff[0], 2);
  endproperty
  a_imae: assert property (p_imae) else $error("trigger did not force level");
endmodule // tmr1_channel_monitor

bind tmr1_channel tmr1_channel_monitor u_tmr1_channel_monitor (.clk(clk), .rst_b(rst_b),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .counter_value(counter_value), .count_down(count_down), .update_event(update_event),
  .trigger_event(trigger_event), .output_reference_signal(output_reference_signal));

// file: tmr1_channel_tb_top.sv
// Self-checking testbench for the channel 1 output-mode block
`timescale 1ns/1ps

module tmr1_channel_tb_top;
  logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, oref, e;
  logic [15:0] counter_value = 16'h0000;
  logic        count_down = 0, update_event = 0, trigger_event = 0, ovf_udf_event = 0;
  int          n_fail = 0, tests_run = 0;
  always #5 clk = ~clk;
  tmr1_channel u_tmr1_channel (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .counter_value(counter_value), .count_down(count_down),
    .update_event(update_event), .trigger_event(trigger_event),
    .ovf_udf_event(ovf_udf_event), .output_reference_signal(oref));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] cfg(input logic [3:0] m, input logic im, input logic pr);
    return {23'h0, m[3], 2'h0, im, pr, 1'b0, m[2:0]};
  endfunction
  task automatic step(input logic [15:0] c, input logic dn);
    @(posedge clk);
    counter_value <= c;
    count_down <= dn;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    {update_event, trigger_event, ovf_udf_event} <= 3'b100 >> k;
    @(posedge clk);
    {update_event, trigger_event, ovf_udf_event} <= 3'b000;
    @(posedge clk);
    #1;
  endtask
  function automatic logic pwm_exp(input logic [3:0] m, input logic [15:0] c, input logic dn);
    return (dn ? !(c > (m[3] ? 16'h0010 : 16'h0020)) : (c < 16'h0020)) ^ m[0];
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    apb(0, tmr1_pkg::CFG_OFS, 32'h0);
    chk("config reset", r, 32'h0000_0000);
    apb(1, tmr1_pkg::CFG_OFS, 32'hffff_ffff);
    apb(0, tmr1_pkg::CFG_OFS, 32'h0);
    chk("config bits", r, 32'h0000_0137);
    apb(0, 12'h100, 32'h0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    chk("unmapped data", r, 32'h0);
    apb(1, tmr1_pkg::CFG_OFS, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_match();
    logic [3:0] ms[5] = '{4'h2, 4'h0, 4'h1, 4'h3, 4'h3};
    logic       ex[5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    apb(1, tmr1_pkg::CMP_OFS, 32'h0000_0005);
    for (int i = 0; i < 5; i++) begin
      apb(1, tmr1_pkg::CFG_OFS, cfg(ms[i], 0, 0));
      step(16'h0006, 0);
      step(16'h0005, 0);
      chk("match level", {31'h0, oref}, {31'h0, ex[i]});
    end
    step(16'h0005, 0);
    chk("parked match", {31'h0, oref}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      apb(1, tmr1_pkg::CFG_OFS, cfg(4'h5 - 4'(i), 0, 0));
      step(16'h0005 + 16'(i), 0);
      chk("forced level", {31'h0, oref}, {31'h0, ~i[0]});
    end
    $display("test match done");
  endtask
  task automatic t_pwm();
    logic [3:0]  ms[4] = '{4'h6, 4'h7, 4'he, 4'hf};
    logic [15:0] cs[3] = '{16'h0008, 16'h0018, 16'h0030};
    apb(1, tmr1_pkg::CMP_OFS, 32'h0000_0020);
    apb(1, tmr1_pkg::ACMP_OFS, 32'h0000_0010);
    // Asym modes only run with up and down counting, as centre-aligned software would
    foreach (ms[i]) begin
      apb(1, tmr1_pkg::CFG_OFS, cfg(ms[i], 0, 0));
      for (int d = 0; d < 2; d++)
        foreach (cs[j]) begin
          step(cs[j], d[0]);
          chk("pwm level", {31'h0, oref}, {31'h0, pwm_exp(ms[i], cs[j], d[0])});
        end
    end
    $display("test pwm done");
  endtask
  task automatic t_imae();
    for (int i = 0; i < 2; i++) begin
      apb(1, tmr1_pkg::CFG_OFS, cfg(4'h6 + i, 1, 0));
      step(16'h0008, 0);
      chk("before trigger", {31'h0, oref}, !i);
      pulse(1);
      chk("forced by trigger", {31'h0, oref}, i);
      step(16'h0009, 0);
      chk("force holds", {31'h0, oref}, i);
      pulse(2);
      chk("force ends", {31'h0, oref}, !i);
    end
    $display("test immediate done");
  endtask
  task automatic t_preload();
    apb(1, tmr1_pkg::CFG_OFS, cfg(4'h6, 0, 1));
    apb(1, tmr1_pkg::CMP_OFS, 32'h0000_0010);
    step(16'h0018, 0);
    chk("buffered write", {31'h0, oref}, 32'h1);
    apb(0, tmr1_pkg::CMP_OFS, 32'h0);
    chk("buffer read", r, 32'h0000_0010);
    pulse(0);
    chk("update copy", {31'h0, oref}, 32'h0);
    apb(0, tmr1_pkg::STAT_OFS, 32'h0);
    chk("status word", r, 32'h0010_0000);
    $display("test preload done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_match();
    t_pwm();
    t_imae();
    t_preload();
    print_verdict();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // tmr1_channel_tb_top

// file: tmr1_oref_calc.sv
// Next-level computation for the channel output reference signal
`timescale 1ns/1ps

module tmr1_oref_calc (
  input  wire logic [3:0]                  mode,
  input  wire logic [tmr1_pkg::CNT_W-1:0]  cnt,
  input  wire logic [tmr1_pkg::CNT_W-1:0]  cmp,
  input  wire logic [tmr1_pkg::CNT_W-1:0]  acmp,
  input  wire logic                        down,
  input  wire logic                        ref_q,
  input  wire logic                        match_edge,
  input  wire logic                        force_on,
  output logic                             ref_nxt
);

  // ----------------------------------------------------------------
  // Level per mode
  // ----------------------------------------------------------------
  always_comb begin
    ref_nxt = ref_q;
    case (mode)
      tmr1_pkg::OM_HOLD: begin
        ref_nxt = ref_q; // R2
      end
      tmr1_pkg::OM_LOW: begin
        if (match_edge) begin
          ref_nxt = 1'b0; // R2
        end
      end
      tmr1_pkg::OM_HIGH: begin
        if (match_edge) begin
          ref_nxt = 1'b1; // R2
        end
      end
      tmr1_pkg::OM_TOGGLE: begin
        if (match_edge) begin
          ref_nxt = ~ref_q; // R2
        end
      end
      tmr1_pkg::OM_F_INACT: begin
        ref_nxt = 1'b0; // R3
      end
      tmr1_pkg::OM_F_ACT: begin
        ref_nxt = 1'b1; // R3
      end
      tmr1_pkg::OM_PWM1: begin
        ref_nxt = down ? !(cnt > cmp) : (cnt < cmp); // R4
      end
      tmr1_pkg::OM_PWM2: begin
        ref_nxt = down ? (cnt > cmp) : !(cnt < cmp); // R5
      end
      tmr1_pkg::OM_APWM1: begin
        ref_nxt = down ? !(cnt > acmp) : (cnt < cmp); // R6
      end
      tmr1_pkg::OM_APWM2: begin
        ref_nxt = down ? (cnt > acmp) : !(cnt < cmp); // R7
      end
      default: begin
        ref_nxt = ref_q;
      end
    endcase
    // Matched level: inactive for PWM1, active for PWM2
    if (force_on) begin
      ref_nxt = (mode == tmr1_pkg::OM_PWM2); // R9
    end
  end

endmodule // tmr1_oref_calc

// file: tmr1_pkg.sv
// Constants and state type for the channel 1 output-mode block
package tmr1_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W  = 16;
  localparam int unsigned ADDR_W = 12;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CFG_OFS  = 12'h044;
  localparam logic [ADDR_W-1:0] CMP_OFS  = 12'h080;
  localparam logic [ADDR_W-1:0] ACMP_OFS = 12'h084;
  localparam logic [ADDR_W-1:0] STAT_OFS = 12'h088;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned MODE_HI_BIT = 8;
  localparam int unsigned IMAE_BIT    = 5;
  localparam int unsigned PRE_BIT     = 4;
  localparam int unsigned STAT_REF    = 0;
  localparam int unsigned STAT_FORCE  = 1;
  localparam int unsigned STAT_CMP_LO = 16;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0]      CFG_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Output mode codes
  // ----------------------------------------------------------------
  localparam logic [3:0] OM_HOLD   = 4'h0;
  localparam logic [3:0] OM_LOW    = 4'h1;
  localparam logic [3:0] OM_HIGH   = 4'h2;
  localparam logic [3:0] OM_TOGGLE = 4'h3;
  localparam logic [3:0] OM_F_INACT = 4'h4;
  localparam logic [3:0] OM_F_ACT  = 4'h5;
  localparam logic [3:0] OM_PWM1   = 4'h6;
  localparam logic [3:0] OM_PWM2   = 4'h7;
  localparam logic [3:0] OM_APWM1  = 4'he;
  localparam logic [3:0] OM_APWM2  = 4'hf;

  // ----------------------------------------------------------------
  // Block state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0]       mode;
    logic             imae;
    logic             pre;
    logic [CNT_W-1:0] cmp_act;
    logic [CNT_W-1:0] cmp_buf;
    logic [CNT_W-1:0] acmp_act;
    logic [CNT_W-1:0] acmp_buf;
    logic             oref;
    logic             force_on;
    logic             match_d;
    logic [31:0]      rdata;
    logic             slverr;
  } tmr1_state_s;

endpackage
